// ### rtl/cie_pkg.sv
package cie_pkg;
	localparam int CIE_ADDR_W = 12;
	localparam int CIE_NUM_EVT = 4;
	// register byte offsets
	localparam logic [11:0] CIE_OFF_EVT_READY = 12'h100;
	localparam logic [11:0] CIE_OFF_EVT_DOWN = 12'h104;
	localparam logic [11:0] CIE_OFF_EVT_UP = 12'h108;
	localparam logic [11:0] CIE_OFF_EVT_ANY = 12'h10c;
	// spacing between the four event flag words
	localparam logic [11:0] CIE_EVT_STRIDE = 12'h004;
	localparam logic [11:0] CIE_OFF_IRQ_ENABLE = 12'h300;
	localparam logic [11:0] CIE_OFF_IRQ_ENABLE_SET = 12'h304;
	localparam logic [11:0] CIE_OFF_IRQ_ENABLE_CLEAR = 12'h308;
	localparam logic [11:0] CIE_OFF_IRQ_STATUS = 12'h310;
	localparam logic [11:0] CIE_OFF_IRQ_MASK = 12'h314;
	// bit positions of the four events
	localparam int CIE_BIT_READY = 0;
	localparam int CIE_BIT_DOWN = 1;
	localparam int CIE_BIT_UP = 2;
	localparam int CIE_BIT_ANY = 3;
	localparam logic [3:0] CIE_ENABLE_RST = 4'h0;
	localparam logic [3:0] CIE_MASK_RST = 4'hf;
	localparam logic [31:0] CIE_UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ### rtl/cie_comparator_irq_enable.sv
`timescale 1ns/100ps
// Summary of operation
// - a read/write enable register holds one interrupt enable bit per event, 1 enables.
// - writing a 1 to a bit of the set view turns that event's enable on.
// - reading the set view returns the current enable state.
// - writing a 1 to a bit of the clear view turns that event's enable off.
// - reading the clear view returns the same enable state as the other views.
// - the any-crossing enable is set and cleared on its own, apart from down and up.
// - the ready event is flagged once the comparator has started with valid output.
// - the any-crossing event is flagged on either a downward or an upward crossing.
module cie_comparator_irq_enable
	import cie_pkg::*;
#(
	parameter int NUM_EVT = CIE_NUM_EVT
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [CIE_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic comp_ready,
	input wire logic comp_down,
	input wire logic comp_up,
	output logic irq_request_r,
	output logic irq_r
);

	logic [NUM_EVT-1:0] enable_r;
	logic [NUM_EVT-1:0] event_r;
	logic [NUM_EVT-1:0] status_r;
	logic [NUM_EVT-1:0] mask_r;
	logic [NUM_EVT-1:0] evt_in;
	logic [NUM_EVT-1:0] evt_clr;
	logic [31:0] readdata_nxt;
	logic ack_r;
	logic access;
	logic wr_lane0;
	logic [NUM_EVT-1:0] wbits;

	// one wait cycle per access keeps read data registered
	assign access = (avs_read | avs_write) & ~ack_r;
	assign wr_lane0 = avs_write & ~ack_r & avs_byteenable[0];
	assign wbits = avs_writedata[NUM_EVT-1:0];

	assign evt_in[CIE_BIT_READY] = comp_ready;
	assign evt_in[CIE_BIT_DOWN] = comp_down;
	assign evt_in[CIE_BIT_UP] = comp_up;
	assign evt_in[CIE_BIT_ANY] = comp_down | comp_up;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= access;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~access;
		end
	end

	// enable state shared by the three views
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_r <= CIE_ENABLE_RST;
		end else if (wr_lane0) begin
			case (avs_address)
				CIE_OFF_IRQ_ENABLE: begin
					enable_r <= wbits;
				end
				CIE_OFF_IRQ_ENABLE_SET: begin
					enable_r <= enable_r | wbits;
				end
				CIE_OFF_IRQ_ENABLE_CLEAR: begin
					enable_r <= enable_r & ~wbits;
				end
				default: begin
					enable_r <= enable_r;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= CIE_MASK_RST;
		end else if (wr_lane0 && avs_address == CIE_OFF_IRQ_MASK) begin
			mask_r <= wbits;
		end
	end

	// event flags: writing 0 clears; a new event in the same cycle wins
	genvar g;
	generate
		for (g = 0; g < NUM_EVT; g++) begin : g_evt
			assign evt_clr[g] = wr_lane0 && !wbits[0]
				&& avs_address == CIE_OFF_EVT_READY + 12'(CIE_EVT_STRIDE * g);
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					event_r[g] <= 1'b0;
				end else if (evt_in[g]) begin
					event_r[g] <= 1'b1;
				end else if (evt_clr[g]) begin
					event_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// sticky status, cleared by reading it; a fresh event is not lost
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
		end else if (avs_read && !ack_r && avs_address == CIE_OFF_IRQ_STATUS) begin
			status_r <= evt_in;
		end else begin
			status_r <= status_r | evt_in;
		end
	end

	always_comb begin
		readdata_nxt = CIE_UNMAPPED_DATA;
		case (avs_address)
			CIE_OFF_EVT_READY: readdata_nxt[0] = event_r[CIE_BIT_READY];
			CIE_OFF_EVT_DOWN: readdata_nxt[0] = event_r[CIE_BIT_DOWN];
			CIE_OFF_EVT_UP: readdata_nxt[0] = event_r[CIE_BIT_UP];
			CIE_OFF_EVT_ANY: readdata_nxt[0] = event_r[CIE_BIT_ANY];
			CIE_OFF_IRQ_ENABLE: readdata_nxt[NUM_EVT-1:0] = enable_r;
			CIE_OFF_IRQ_ENABLE_SET: readdata_nxt[NUM_EVT-1:0] = enable_r;
			CIE_OFF_IRQ_ENABLE_CLEAR: readdata_nxt[NUM_EVT-1:0] = enable_r;
			CIE_OFF_IRQ_STATUS: readdata_nxt[NUM_EVT-1:0] = status_r;
			CIE_OFF_IRQ_MASK: readdata_nxt[NUM_EVT-1:0] = mask_r;
			default: readdata_nxt = CIE_UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= CIE_UNMAPPED_DATA;
		end else if (avs_read && !ack_r) begin
			avs_readdata <= readdata_nxt;
		end
	end

	// request follows the enabled event flags, one cycle behind
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_request_r <= 1'b0;
		end else begin
			irq_request_r <= |(event_r & enable_r);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(status_r & mask_r);
		end
	end

endmodule

// ### tb/cie_monitor.sv
`timescale 1ns/100ps
module cie_monitor
	import cie_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [CIE_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic comp_ready,
	input wire logic comp_down,
	input wire logic comp_up,
	input wire logic irq_request_r,
	input wire logic irq_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// shadow lags the design by one edge, so irq checks skip cycles with a write held
	logic [3:0] en_r;
	logic [3:0] msk_r;
	wire wr_ok = !avs_waitrequest && avs_write && avs_byteenable[0];
	wire rd_ok = !avs_waitrequest && avs_read;
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n) en_r <= 4'h0;
		else if (wr_ok && avs_address == CIE_OFF_IRQ_ENABLE) en_r <= avs_writedata[3:0];
		else if (wr_ok && avs_address == CIE_OFF_IRQ_ENABLE_SET) en_r <= en_r | avs_writedata[3:0];
		else if (wr_ok && avs_address == CIE_OFF_IRQ_ENABLE_CLEAR) en_r <= en_r & ~avs_writedata[3:0];
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n) msk_r <= CIE_MASK_RST;
		else if (wr_ok && avs_address == CIE_OFF_IRQ_MASK) msk_r <= avs_writedata[3:0];
	chk_view_direct: assert property (
		rd_ok && avs_address == 12'h300 |-> avs_readdata == {28'h0, en_r}) else $error("direct bad");
	chk_view_set: assert property (
		rd_ok && avs_address == 12'h304 |-> avs_readdata == {28'h0, en_r}) else $error("set bad");
	chk_view_clear: assert property (
		rd_ok && avs_address == 12'h308 |-> avs_readdata == {28'h0, en_r}) else $error("clear bad");
	// flag is set at the event edge, the request follows one edge later
	chk_ready_irq: assert property (
		comp_ready && en_r[0] && !avs_write ##1 !avs_write |=> irq_request_r)
		else $error("ready irq bad");
	chk_any_irq: assert property (
		(comp_down || comp_up) && en_r[3] && !avs_write ##1 !avs_write |=> irq_request_r)
		else $error("any bad");
	chk_irq_masked: assert property (
		msk_r == 4'h0 && !avs_write |=> !irq_r) else $error("irq not masked");
	chk_irq_off: assert property (
		en_r == 4'h0 && !avs_write |=> !irq_request_r) else $error("irq not gated");
	chk_wait_ack: assert property (
		$rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest) else $error("no ack");
	chk_wait_one: assert property (
		!avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
endmodule
bind cie_comparator_irq_enable cie_monitor i_cie_monitor (.sys_clk, .reset_n, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.comp_ready, .comp_down, .comp_up, .irq_request_r, .irq_r);

// ### tb/cie_comparator_irq_enable_bench.sv
`timescale 1ns/100ps
module cie_comparator_irq_enable_bench
	import cie_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
	logic comp_ready = 0, comp_down = 0, comp_up = 0;
	logic [11:0] avs_address = 12'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [3:0] avs_byteenable = 4'h1;
	logic avs_waitrequest, irq_request_r, irq_r;
	int bad_count = 0, comparisons = 0;
	cie_comparator_irq_enable i_cie_comparator_irq_enable (.sys_clk, .reset_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .comp_ready, .comp_down, .comp_up, .irq_request_r, .irq_r);
	always #2 sys_clk = ~sys_clk;
	task automatic close_out;
		$display("errors %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	// one idle edge after each access keeps request strobes from being set twice at one step
	task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			bad_count++;
			close_out;
		end else begin
			q = avs_readdata;
			avs_read <= 0;
			avs_write <= 0;
			@(posedge sys_clk);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(a, 1, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(a, 0, 32'h0, q);
		chk(q, e);
	endtask
	task automatic pulse(input logic [2:0] p);
		{comp_up, comp_down, comp_ready} <= p;
		@(posedge sys_clk);
		{comp_up, comp_down, comp_ready} <= 3'b000;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic t_views;
		rd(12'h308, 32'h0);
		wr(12'h300, 32'h5);
		rd(12'h304, 32'h5);
		wr(12'h304, 32'h8);
		rd(12'h308, 32'hd);
		wr(12'h308, 32'h1);
		wr(12'h304, 32'h0);
		rd(12'h300, 32'hc);
		wr(12'h308, 32'h8);
		rd(12'h304, 32'h4);
		rd(12'h200, 32'h0);
	endtask
	task automatic t_irq;
		pulse(3'b010);
		chk({31'h0, irq_request_r}, 32'h0);
		wr(12'h300, 32'h8);
		chk({31'h0, irq_request_r}, 32'h1);
		wr(12'h10c, 32'h0);
		chk({31'h0, irq_request_r}, 32'h0);
		wr(12'h300, 32'h1);
		pulse(3'b001);
		chk({31'h0, irq_request_r}, 32'h1);
	endtask
	task automatic t_status;
		wr(12'h300, 32'h8);
		pulse(3'b100);
		rd(12'h314, 32'hf);
		chk({31'h0, irq_r}, 32'h1);
		wr(12'h314, 32'h0);
		chk({31'h0, irq_r}, 32'h0);
		wr(12'h314, 32'hf);
		rd(12'h310, 32'hf);
		@(posedge sys_clk);
		chk({31'h0, irq_r}, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		reset_n <= 1;
		@(posedge sys_clk);
		t_views;
		t_irq;
		t_status;
		close_out;
	end
endmodule
